//--- logic/hp_status_pkg.sv
// Register map, field positions and reset values of the slot status block
`default_nettype none
package hp_status_pkg;
  // Word indices; byte address is four times the index
  localparam logic [9:0]  IDX_SLOT_STATUS = 10'h05a;
  localparam logic [9:0]  IDX_DEV_CAP2    = 10'h064;
  localparam logic [9:0]  IDX_DEV_CTL2    = 10'h068;
  localparam logic [9:0]  IDX_SLOT_CTL    = 10'h0c0;
  localparam logic [9:0]  IDX_EVENT_MASK  = 10'h0c1;
  localparam int          ADDR_W          = 12;

  // Slot status field positions
  localparam int          BIT_ATTN        = 0;
  localparam int          BIT_PFAULT      = 1;
  localparam int          BIT_LATCH_CHG   = 2;
  localparam int          BIT_PRES_CHG    = 3;
  localparam int          BIT_CMD_DONE    = 4;
  localparam int          BIT_LATCH_ST    = 5;
  localparam int          BIT_PRES_ST     = 6;
  localparam int          BIT_ILOCK_ST    = 7;
  localparam int          BIT_LINK_CHG    = 8;
  localparam int          STATUS_W        = 9;
  localparam logic [8:0]  RW1C_MASK       = 9'h11f;
  localparam logic [8:0]  STATUS_RESET    = 9'h000;
  localparam logic [8:0]  MASK_RESET      = 9'h000;

  // Capability and control field positions
  localparam int          BIT_FWD         = 5;
  localparam logic        FWD_SUP_RESET   = 1'b1;
  localparam logic        FWD_EN_RESET    = 1'b0;
  localparam int          SLOT_CTL_W      = 16;
  localparam logic [15:0] SLOT_CTL_RESET  = 16'h0000;

  // Synchronised input positions
  localparam int          IN_ATTN         = 0;
  localparam int          IN_PFAULT       = 1;
  localparam int          IN_LATCH        = 2;
  localparam int          IN_PRES         = 3;
  localparam int          IN_ILOCK        = 4;
  localparam int          IN_LINK         = 5;
  localparam int          IN_EXP_BUSY     = 6;
  localparam int          IN_W            = 7;

  typedef enum logic [2:0] {
    REG_NONE, REG_STATUS, REG_CAP2, REG_CTL2, REG_SCTL, REG_MASK
  } reg_sel_t;
endpackage
`default_nettype wire

//--- logic/sync2.sv
// Two flip-flop synchroniser for a vector of independent levels
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule // sync2
`default_nettype wire

//--- logic/cmd_tracker.sv
// Tracks one slot control command until its expander work is over
`default_nettype none
module cmd_tracker (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic issue,
  input  wire logic use_expander,
  input  wire logic exp_busy,
  output logic      done
);
  typedef enum logic [1:0] {IDLE, WAIT_START, WAIT_END} trk_state_t;
  trk_state_t state_q;

  // Completion once the expander has taken and finished the work, or the cycle after issue when the expander is not used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= IDLE;
    end else if (issue) begin
      state_q <= use_expander ? WAIT_START : IDLE;
    end else begin
      unique case (state_q)
        IDLE:       state_q <= IDLE;
        WAIT_START: state_q <= exp_busy ? WAIT_END : WAIT_START;
        WAIT_END:   state_q <= exp_busy ? WAIT_END : IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else begin
      done <= (issue && !use_expander) ||
              (!issue && state_q == WAIT_END && !exp_busy);
    end
  end
endmodule // cmd_tracker
`default_nettype wire

//--- logic/hotplug_slot_status_regs.sv
// Slot status, forwarding capability and slot command registers over APB
//
// Added by the designer: register access over APB.
`default_nettype none
module hotplug_slot_status_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Slot pins and port configuration
  input  wire logic        attn_button,
  input  wire logic        power_fault,
  input  wire logic        latch_open,
  input  wire logic        card_present,
  input  wire logic        port_interlock_input,
  input  wire logic        link_active,
  input  wire logic        expander_busy,
  input  wire logic        port_is_upstream,
  input  wire logic        slot_implemented,
  input  wire logic        expander_enabled,
  input  wire logic        hp_on_gpio,
  input  wire logic        cap_lock,
  // Slot command towards the expander logic, forwarding enable and interrupt
  output logic             slot_cmd_issue,
  output logic      [15:0] slot_control_reg,
  output logic             alt_routing_fwd_enable,
  output logic             irq
);

  // Register decode shared by the read and the write path
  function automatic hp_status_pkg::reg_sel_t decode(
    input logic [11:0] addr
  );
    logic [9:0] idx;
    idx = addr[11:2];
    if (addr[1:0] != 2'b00) begin
      decode = hp_status_pkg::REG_NONE;
    end else if (idx == hp_status_pkg::IDX_SLOT_STATUS) begin
      decode = hp_status_pkg::REG_STATUS;
    end else if (idx == hp_status_pkg::IDX_DEV_CAP2) begin
      decode = hp_status_pkg::REG_CAP2;
    end else if (idx == hp_status_pkg::IDX_DEV_CTL2) begin
      decode = hp_status_pkg::REG_CTL2;
    end else if (idx == hp_status_pkg::IDX_SLOT_CTL) begin
      decode = hp_status_pkg::REG_SCTL;
    end else if (idx == hp_status_pkg::IDX_EVENT_MASK) begin
      decode = hp_status_pkg::REG_MASK;
    end else begin
      decode = hp_status_pkg::REG_NONE;
    end
  endfunction

  localparam int N_IN = hp_status_pkg::IN_W;

  logic [N_IN-1:0] pins_raw;
  logic [N_IN-1:0] pins_s;
  logic [N_IN-1:0] pins_prev_q;
  logic            pins_valid_q;
  logic [1:0]      prime_q;
  logic [4:0]      cfg_raw;
  logic [4:0]      cfg_s;
  logic            upstream;
  logic            slot_impl;
  logic            exp_en;
  logic            on_gpio;
  logic            locked;

  logic [8:0]      status_q;
  logic [8:0]      mask_q;
  logic [8:0]      ev_set;
  logic [8:0]      ev_clr;
  logic [8:0]      status_view;
  logic            fwd_sup_q;
  logic            fwd_en_q;
  logic            fwd_sup_view;
  logic            fwd_en_view;
  logic            cmd_done;
  logic            use_expander;

  logic            setup;
  logic            access;
  logic            wr_access;
  hp_status_pkg::reg_sel_t sel;
  logic [31:0]     rd_word;

  // Pins and straps cross into the register clock
  assign pins_raw = {expander_busy, link_active, port_interlock_input,
                     card_present, latch_open, power_fault, attn_button};
  assign cfg_raw  = {cap_lock, hp_on_gpio, expander_enabled,
                     slot_implemented, port_is_upstream};

  sync2 #(
    .W        (N_IN)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  sync2 #(
    .W        (5)
  ) u_cfg_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (cfg_raw),
    .sync_out (cfg_s)
  );

  assign upstream  = cfg_s[0];
  assign slot_impl = cfg_s[1];
  assign exp_en    = cfg_s[2];
  assign on_gpio   = cfg_s[3];
  assign locked    = cfg_s[4];

  // Previous pin levels; edges are ignored until the synchroniser has
  // filled, so a pin already high at reset raises no false event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev_q  <= '0;
      prime_q      <= 2'h0;
      pins_valid_q <= 1'b0;
    end else begin
      pins_prev_q  <= pins_s;
      prime_q      <= {prime_q[0], 1'b1};
      pins_valid_q <= prime_q[1];
    end
  end

  // APB phases
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign pready    = 1'b1;
  assign wr_access = access && pwrite;
  assign sel       = decode(paddr);

  // Event detection
  always_comb begin
    ev_set = '0;
    ev_set[hp_status_pkg::BIT_ATTN] = pins_valid_q &&
      pins_s[hp_status_pkg::IN_ATTN] && !pins_prev_q[hp_status_pkg::IN_ATTN];
    ev_set[hp_status_pkg::BIT_PFAULT] = pins_valid_q &&
      pins_s[hp_status_pkg::IN_PFAULT] &&
      !pins_prev_q[hp_status_pkg::IN_PFAULT];
    ev_set[hp_status_pkg::BIT_LATCH_CHG] = pins_valid_q &&
      (pins_s[hp_status_pkg::IN_LATCH] !=
       pins_prev_q[hp_status_pkg::IN_LATCH]);
    ev_set[hp_status_pkg::BIT_PRES_CHG] = pins_valid_q &&
      (pins_s[hp_status_pkg::IN_PRES] !=
       pins_prev_q[hp_status_pkg::IN_PRES]);
    ev_set[hp_status_pkg::BIT_CMD_DONE] = cmd_done;
    ev_set[hp_status_pkg::BIT_LINK_CHG] = pins_valid_q &&
      (pins_s[hp_status_pkg::IN_LINK] !=
       pins_prev_q[hp_status_pkg::IN_LINK]);
  end

  assign ev_clr = (wr_access && sel == hp_status_pkg::REG_STATUS) ?
                  (pwdata[8:0] & hp_status_pkg::RW1C_MASK) : 9'h000;

  for (genvar b = 0; b < hp_status_pkg::STATUS_W; b++) begin : g_flag
    if (hp_status_pkg::RW1C_MASK[b]) begin : g_rw1c
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          status_q[b] <= hp_status_pkg::STATUS_RESET[b];
        end else begin
          status_q[b] <= ev_set[b] || (status_q[b] && !ev_clr[b]);
        end
      end
    end else begin : g_ro
      assign status_q[b] = 1'b0;
    end
  end

  // Read view of the slot status register
  always_comb begin
    status_view = status_q;
    status_view[hp_status_pkg::BIT_LATCH_ST] =
      pins_s[hp_status_pkg::IN_LATCH];
    if (upstream) begin
      status_view[hp_status_pkg::BIT_PRES_ST] = 1'b0;
    end else if (slot_impl) begin
      status_view[hp_status_pkg::BIT_PRES_ST] =
        pins_s[hp_status_pkg::IN_PRES];
    end else begin
      status_view[hp_status_pkg::BIT_PRES_ST] = 1'b1;
    end
    status_view[hp_status_pkg::BIT_ILOCK_ST] = exp_en && !on_gpio &&
      pins_s[hp_status_pkg::IN_ILOCK];
  end

  // Slot control write issues one command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_control_reg <= hp_status_pkg::SLOT_CTL_RESET;
    end else if (wr_access && sel == hp_status_pkg::REG_SCTL) begin
      slot_control_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cmd_issue <= 1'b0;
    end else begin
      slot_cmd_issue <= wr_access && sel == hp_status_pkg::REG_SCTL;
    end
  end

  assign use_expander = exp_en && !on_gpio;

  cmd_tracker u_cmd (
    .pclk         (pclk),
    .presetn      (presetn),
    .issue        (slot_cmd_issue),
    .use_expander (use_expander),
    .exp_busy     (pins_s[hp_status_pkg::IN_EXP_BUSY]),
    .done         (cmd_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_sup_q <= hp_status_pkg::FWD_SUP_RESET;
    end else if (wr_access && sel == hp_status_pkg::REG_CAP2 &&
                 !locked && !upstream) begin
      fwd_sup_q <= pwdata[hp_status_pkg::BIT_FWD];
    end
  end

  assign fwd_sup_view = fwd_sup_q && !upstream;

  // enable forced to zero without support
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_en_q <= hp_status_pkg::FWD_EN_RESET;
    end else if (!fwd_sup_view) begin
      fwd_en_q <= 1'b0;
    end else if (wr_access && sel == hp_status_pkg::REG_CTL2) begin
      fwd_en_q <= pwdata[hp_status_pkg::BIT_FWD];
    end
  end

  assign fwd_en_view = fwd_en_q && fwd_sup_view;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_routing_fwd_enable <= 1'b0;
    end else begin
      alt_routing_fwd_enable <= fwd_en_view;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= hp_status_pkg::MASK_RESET;
    end else if (wr_access && sel == hp_status_pkg::REG_MASK) begin
      mask_q <= pwdata[8:0] & hp_status_pkg::RW1C_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // Read mux; unused bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (sel)
      hp_status_pkg::REG_STATUS: rd_word[8:0] = status_view;
      hp_status_pkg::REG_CAP2:
        rd_word[hp_status_pkg::BIT_FWD] = fwd_sup_view;
      hp_status_pkg::REG_CTL2:
        rd_word[hp_status_pkg::BIT_FWD] = fwd_en_view;
      hp_status_pkg::REG_SCTL:   rd_word[15:0] = slot_control_reg;
      hp_status_pkg::REG_MASK:   rd_word[8:0] = mask_q;
      hp_status_pkg::REG_NONE:   rd_word = 32'h0000_0000;
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= (sel == hp_status_pkg::REG_NONE);
    end
  end

endmodule // hotplug_slot_status_regs
`default_nettype wire

//--- tb/hotplug_slot_status_regs_sva.sv
// Port level checks of the slot status block
`default_nettype none
module hotplug_slot_status_regs_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        slot_cmd_issue,
  input wire logic [15:0] slot_control_reg,
  input wire logic        alt_routing_fwd_enable,
  input wire logic        latch_open,
  input wire logic        card_present,
  input wire logic        port_interlock_input,
  input wire logic        port_is_upstream,
  input wire logic        slot_implemented,
  input wire logic        expander_enabled,
  input wire logic        hp_on_gpio
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] v, p1_q, p2_q, p3_q;
  logic       calm, rd_st, rd_cap, wr_ctl;
  assign v = {latch_open, card_present, port_interlock_input,
    port_is_upstream, slot_implemented, expander_enabled, hp_on_gpio};
  assign calm = (v == p1_q) && (v == p2_q) && (v == p3_q);
  assign rd_st = psel && !penable && !pwrite &&
    paddr == {hp_status_pkg::IDX_SLOT_STATUS, 2'b00};
  assign rd_cap = psel && !penable && !pwrite &&
    paddr == {hp_status_pkg::IDX_DEV_CAP2, 2'b00};
  assign wr_ctl = psel && penable && pwrite &&
    paddr == {hp_status_pkg::IDX_SLOT_CTL, 2'b00};
  // Inputs held steady long enough to pass the synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_q <= '0;
      p2_q <= '0;
      p3_q <= '0;
    end else begin
      p1_q <= v;
      p2_q <= p1_q;
      p3_q <= p2_q;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_CMD_ISSUE: assert property (slot_cmd_issue |-> $past(wr_ctl))
    else $error("command pulse without slot control write");
  AST_CMD_ONE: assert property (wr_ctl |=> slot_cmd_issue &&
    slot_control_reg == $past(pwdata[15:0]))
    else $error("slot control write not taken as one command");
  AST_LATCH: assert property (rd_st && calm |=>
    prdata[5] == $past(latch_open)) else $error("latch state wrong");
  AST_PRES_SLOT: assert property (rd_st && calm && !port_is_upstream &&
    slot_implemented |=> prdata[6] == $past(card_present))
    else $error("presence state wrong");
  AST_PRES_NOSLOT: assert property (rd_st && calm && !port_is_upstream &&
    !slot_implemented |=> prdata[6]) else $error("no slot presence not one");
  AST_PRES_UP: assert property (rd_st && calm && port_is_upstream |=>
    !prdata[6]) else $error("upstream presence not zero");
  AST_ILOCK: assert property (rd_st && calm |=> prdata[7] ==
    ($past(port_interlock_input) & $past(expander_enabled) &
    !$past(hp_on_gpio))) else $error("interlock status wrong");
  AST_CAP_UP: assert property (rd_cap && calm && port_is_upstream |=>
    !prdata[5]) else $error("upstream forwarding support not zero");
  AST_FWD_RO: assert property (calm && port_is_upstream |->
    !alt_routing_fwd_enable) else $error("forwarding enable not zero");
endmodule // hotplug_slot_status_regs_sva
`default_nettype wire

//--- tb/slot_pins_model.sv
// Expander side model: busy for a while after each slot command
`default_nettype none
module slot_pins_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slot_cmd_issue,
  input  wire logic [3:0] stall,
  output logic            expander_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= '0;
    else if (slot_cmd_issue) cnt_q <= 5'(stall) + 5'd3;
    else if (cnt_q != 5'd0) cnt_q <= cnt_q - 5'd1;
  end
  // Two idle cycles, then busy for stall plus one cycles
  assign expander_busy = (cnt_q != 5'd0) && (cnt_q <= 5'(stall) + 5'd1);
endmodule // slot_pins_model
`default_nettype wire

//--- tb/tb_hotplug_slot_status_regs.sv
// Self-checking bench of the slot status block
`default_nettype none
module tb_hotplug_slot_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_ST = {hp_status_pkg::IDX_SLOT_STATUS, 2'b00};
  localparam logic [11:0] A_CAP = {hp_status_pkg::IDX_DEV_CAP2, 2'b00};
  localparam logic [11:0] A_CTL2 = {hp_status_pkg::IDX_DEV_CTL2, 2'b00};
  localparam logic [11:0] A_SCTL = {hp_status_pkg::IDX_SLOT_CTL, 2'b00};
  localparam logic [11:0] A_MASK = {hp_status_pkg::IDX_EVENT_MASK, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        attn_button, power_fault, latch_open, card_present;
  logic        port_interlock_input, link_active, expander_busy;
  logic        port_is_upstream, slot_implemented, expander_enabled;
  logic        hp_on_gpio, cap_lock, slot_cmd_issue;
  logic        alt_routing_fwd_enable, irq;
  logic [15:0] slot_control_reg;
  logic [3:0]  stall;
  int          n_mismatch, total_checks, seed;
  hotplug_slot_status_regs u_hotplug_slot_status_regs (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .attn_button, .power_fault, .latch_open, .card_present,
    .port_interlock_input, .link_active, .expander_busy, .port_is_upstream,
    .slot_implemented, .expander_enabled, .hp_on_gpio, .cap_lock,
    .slot_cmd_issue, .slot_control_reg, .alt_routing_fwd_enable, .irq);
  slot_pins_model u_slot_pins_model (.pclk, .presetn, .slot_cmd_issue,
    .stall, .expander_busy);
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Live status bits expected from the current pin and strap levels
  function automatic logic [31:0] live_exp();
    logic [31:0] x;
    x = '0;
    x[hp_status_pkg::BIT_LATCH_ST] = latch_open;
    x[hp_status_pkg::BIT_PRES_ST] = port_is_upstream ? 1'b0 :
      (slot_implemented ? card_present : 1'b1);
    x[hp_status_pkg::BIT_ILOCK_ST] = port_interlock_input &
      expander_enabled & ~hp_on_gpio;
    return x;
  endfunction
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    close_out();
  end
  initial begin
    logic [31:0] e, d;
    {psel, penable, pwrite, paddr, pwdata, attn_button, power_fault} = '0;
    {latch_open, card_present, port_interlock_input, link_active} = '0;
    {port_is_upstream, hp_on_gpio, cap_lock, stall} = '0;
    {slot_implemented, expander_enabled} = 2'b11;
    presetn = 1'b0;
    seed = 32'h4944;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(A_ST);
    chk(rdv, live_exp());
    rd(A_CAP);
    chk(rdv, 32'h20);
    rd(12'h004);
    chk({31'h0, erv}, 32'h1);
    for (int k = 0; k < 5; k++) begin
      e = 32'h1 << ((k == 4) ? 8 : k);
      case (k)
        0: attn_button <= 1'b1;
        1: power_fault <= 1'b1;
        2: latch_open <= ~latch_open;
        3: card_present <= ~card_present;
        default: link_active <= ~link_active;
      endcase
      repeat (5) @(posedge pclk);
      attn_button <= 1'b0;
      power_fault <= 1'b0;
      rd(A_ST);
      chk(rdv, e | live_exp());
      wr(A_ST, 32'h0);
      rd(A_ST);
      chk(rdv, e | live_exp());
      wr(A_ST, 32'h1ff);
      rd(A_ST);
      chk(rdv, live_exp());
    end
    wr(A_MASK, 32'h1);
    attn_button <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(A_ST, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    attn_button <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      stall <= (4'($random(seed)) & 4'h3) + 4'h4;
      hp_on_gpio <= (i == 2);
      d = $random(seed);
      if (i != 1) wr(A_ST, 32'h10);
      wr(A_SCTL, d);
      @(negedge pclk);
      chk({16'h0, slot_control_reg}, {16'h0, d[15:0]});
      repeat (3) @(posedge pclk);
      rd(A_ST);
      chk(rdv & 32'h10, (i != 0) ? 32'h10 : 32'h0);
      repeat (30) @(posedge pclk);
      rd(A_ST);
      chk(rdv & 32'h10, 32'h10);
    end
    wr(A_CTL2, 32'h20);
    repeat (2) @(negedge pclk);
    chk({31'h0, alt_routing_fwd_enable}, 32'h1);
    wr(A_CAP, 32'h0);
    rd(A_CAP);
    chk(rdv, 32'h0);
    rd(A_CTL2);
    chk(rdv, 32'h0);
    chk({31'h0, alt_routing_fwd_enable}, 32'h0);
    cap_lock <= 1'b1;
    repeat (3) @(posedge pclk);
    wr(A_CAP, 32'h20);
    rd(A_CAP);
    chk(rdv, 32'h0);
    cap_lock <= 1'b0;
    repeat (3) @(posedge pclk);
    wr(A_CAP, 32'h20);
    rd(A_CAP);
    chk(rdv, 32'h20);
    wr(A_CTL2, 32'h20);
    port_is_upstream <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(A_CAP, 32'h0);
    rd(A_CAP);
    chk(rdv, 32'h0);
    chk({31'h0, alt_routing_fwd_enable}, 32'h0);
    for (int j = 0; j < 6; j++) begin
      port_is_upstream <= (j > 2);
      slot_implemented <= j[0];
      hp_on_gpio <= (j == 4);
      expander_enabled <= (j != 2);
      card_present <= 1'($random(seed));
      port_interlock_input <= 1'($random(seed));
      latch_open <= 1'($random(seed));
      repeat (5) @(posedge pclk);
      rd(A_ST);
      chk(rdv & 32'he0, live_exp());
    end
    port_is_upstream <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(A_CAP);
    chk(rdv, 32'h20);
    close_out();
  end
endmodule // tb_hotplug_slot_status_regs
bind hotplug_slot_status_regs hotplug_slot_status_regs_sva u_sva (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .slot_cmd_issue, .slot_control_reg, .alt_routing_fwd_enable, .latch_open,
  .card_present, .port_interlock_input, .port_is_upstream,
  .slot_implemented, .expander_enabled, .hp_on_gpio);
`default_nettype wire
